/* File: src/bsf_map.svh */
// Offsets, flag positions, reset values and the behaviour notes of the bit, shift and flag datapath.
`ifndef BSF_MAP_SVH
`define BSF_MAP_SVH
// Notes on behaviour
// - Stack store writes the source register onto stack.
// - Stack load places stack value into destination.
// - I/O bit raise sets bit b of P.
// - I/O bit drop clears bit b of P.
// - Logical left shift, zero enters bit zero.
// - Logical right shift, zero enters bit seven.
// - Rotate left: old carry in, bit seven out.
// - Rotate right: old carry in, bit zero out.
// - Arithmetic right shift keeps bit seven.
// - Nibble exchange swaps the two halves.
// - Status raise/drop sets or clears flag s.
// - Copy source bit b into the transfer flag.
// - Copy transfer flag into destination bit b.
// - Carry and negative raise/drop touch only themselves.
// - Interrupts on sets, off clears the enable.
// - Sign and overflow flags raise and drop.
// - Transfer and zero flags raise and drop.
// - Half carry raise sets the half carry flag.
`define BSF_FLAG_C 3'h0
`define BSF_FLAG_Z 3'h1
`define BSF_FLAG_N 3'h2
`define BSF_FLAG_V 3'h3
`define BSF_FLAG_S 3'h4
`define BSF_FLAG_H 3'h5
`define BSF_FLAG_T 3'h6
`define BSF_FLAG_I 3'h7
`define BSF_ADDR_STATUS 6'h20
`define BSF_ADDR_SP 6'h21
`define BSF_ADDR_RESULT 6'h22
`define BSF_STATUS_RST 8'h00
`define BSF_DATA_RST 8'h00
`endif

/* File: src/bsf_pkg.sv */
// Types shared by the bit, shift and flag datapath files.
package bsf_pkg;

  // One data byte of the core.
  typedef logic [7:0] byte_t;

  // Operations that the decoder may issue to this datapath.
  typedef enum logic [4:0] {
    op_nop                      = 5'h00,
    op_stack_store              = 5'h01,
    op_stack_load               = 5'h02,
    op_io_bit_raise             = 5'h03,
    op_io_bit_drop              = 5'h04,
    op_logical_shift_left       = 5'h05,
    op_logical_shift_right      = 5'h06,
    op_rotate_left_via_carry    = 5'h07,
    op_rotate_right_via_carry   = 5'h08,
    op_arith_shift_right        = 5'h09,
    op_nibble_exchange          = 5'h0A,
    op_status_bit_raise         = 5'h0B,
    op_status_bit_drop          = 5'h0C,
    op_store_bit_to_transfer_flag  = 5'h0D,
    op_load_bit_from_transfer_flag = 5'h0E,
    op_carry_flag_raise         = 5'h0F,
    op_carry_flag_clear         = 5'h10,
    op_negative_flag_raise      = 5'h11,
    op_negative_flag_drop       = 5'h12,
    op_zero_flag_raise          = 5'h13,
    op_zero_flag_drop           = 5'h14,
    op_interrupts_on            = 5'h15,
    op_interrupts_off           = 5'h16,
    op_sign_flag_raise          = 5'h17,
    op_sign_flag_drop           = 5'h18,
    op_overflow_flag_raise      = 5'h19,
    op_overflow_flag_drop       = 5'h1A,
    op_transfer_flag_raise      = 5'h1B,
    op_transfer_flag_drop       = 5'h1C,
    op_half_carry_raise         = 5'h1D
  } op_e;

  // Sequencer states; stack transfers take a second cycle.
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_stack = 2'b01
  } state_e;

endpackage

/* File: src/shift_unit.sv */
// Combinational shifter for the shift, rotate and nibble exchange operations.
`timescale 1ns/1ps
`include "bsf_map.svh"
module shift_unit (
  // Operation and operands.
  input  bsf_pkg::op_e  op,
  input  bsf_pkg::byte_t value,
  input  wire logic     carry_in,
  // Results.
  output bsf_pkg::byte_t result,
  output logic          carry_out,
  output logic          carry_we,
  output logic          hit
);
  import bsf_pkg::*;

  // Pick the shifted byte for the operation in hand.
  always_comb begin
    result    = value;
    carry_out = carry_in;
    carry_we  = 1'b0;
    hit       = 1'b1;
    case (op)
      op_logical_shift_left: begin
        result = {value[6:0], 1'b0};
      end
      op_logical_shift_right: begin
        result = {1'b0, value[7:1]};
      end
      op_rotate_left_via_carry: begin
        result    = {value[6:0], carry_in};
        carry_out = value[7];
        carry_we  = 1'b1;
      end
      op_rotate_right_via_carry: begin
        result    = {carry_in, value[7:1]};
        carry_out = value[0];
        carry_we  = 1'b1;
      end
      op_arith_shift_right: begin
        result = {value[7], value[7:1]};
      end
      op_nibble_exchange: begin
        result = {value[3:0], value[7:4]};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

endmodule

/* File: src/bit_shift_flag_datapath.sv */
// Execution datapath for stack transfers, I/O bit writes, shifts and status flag updates.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "bsf_map.svh"
module bit_shift_flag_datapath #(
  parameter int STACK_DEPTH = 16,
  parameter int IO_W        = 5
) (
  // Clock and synchronous reset.
  input  wire logic            clock,
  input  wire logic            nrst,
  // Instruction issue from the decoder.
  input  wire logic            op_valid,
  input  bsf_pkg::op_e         op,
  input  bsf_pkg::byte_t       src_data,
  input  wire logic [2:0]      bit_index,
  input  wire logic [IO_W-1:0] io_index,
  output logic                 op_ready,
  // Result towards the register file.
  output logic                 res_valid,
  output logic                 res_we,
  output bsf_pkg::byte_t       res_data,
  // Current status register.
  output bsf_pkg::byte_t       status_out,
  // Register port.
  input  wire logic [5:0]      reg_addr,
  input  bsf_pkg::byte_t       reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output bsf_pkg::byte_t       reg_rdata
);
  import bsf_pkg::*;

  // Width of the stack pointer and number of I/O registers.
  localparam int SP_W     = $clog2(STACK_DEPTH);
  localparam int IO_COUNT = 1 << IO_W;

  // Address one above the last I/O register.
  localparam logic [6:0] IO_TOP = 7'(IO_COUNT);

  // Stack pointer value after reset: the top word.
  localparam logic [SP_W-1:0] SP_RST = SP_W'(STACK_DEPTH - 1);

  // Returns a byte with one bit forced to a value.
  function automatic byte_t bit_put(input byte_t v, input logic [2:0] idx, input logic val);
    byte_t r;
    r      = v;
    r[idx] = val;
    return r;
  endfunction

  // Decodes the named flag operations into hit, flag index and new value.
  function automatic logic [4:0] named_flag(input op_e o);
    logic [4:0] r;
    r = 5'h00;
    // Top bit marks a hit, then the flag index, then the new value.
    case (o)
      op_carry_flag_raise:    r = {1'b1, `BSF_FLAG_C, 1'b1};
      op_carry_flag_clear:    r = {1'b1, `BSF_FLAG_C, 1'b0};
      op_negative_flag_raise: r = {1'b1, `BSF_FLAG_N, 1'b1};
      op_negative_flag_drop:  r = {1'b1, `BSF_FLAG_N, 1'b0};
      op_zero_flag_raise:     r = {1'b1, `BSF_FLAG_Z, 1'b1};
      op_zero_flag_drop:      r = {1'b1, `BSF_FLAG_Z, 1'b0};
      op_interrupts_on:       r = {1'b1, `BSF_FLAG_I, 1'b1};
      op_interrupts_off:      r = {1'b1, `BSF_FLAG_I, 1'b0};
      op_sign_flag_raise:     r = {1'b1, `BSF_FLAG_S, 1'b1};
      op_sign_flag_drop:      r = {1'b1, `BSF_FLAG_S, 1'b0};
      op_overflow_flag_raise: r = {1'b1, `BSF_FLAG_V, 1'b1};
      op_overflow_flag_drop:  r = {1'b1, `BSF_FLAG_V, 1'b0};
      op_transfer_flag_raise: r = {1'b1, `BSF_FLAG_T, 1'b1};
      op_transfer_flag_drop:  r = {1'b1, `BSF_FLAG_T, 1'b0};
      op_half_carry_raise:    r = {1'b1, `BSF_FLAG_H, 1'b1};
      default:                r = 5'h00;
    endcase
    return r;
  endfunction

  // Sequencer state and the stack transfer held for its second cycle.
  state_e          state_reg;
  state_e          state_next;
  op_e             pend_op_reg;
  byte_t           pend_data_reg;

  // Architectural state kept in this block.
  byte_t           status_reg;
  byte_t           status_next;
  logic [SP_W-1:0] sp_reg;
  logic [SP_W-1:0] sp_next;
  byte_t           stack_mem [STACK_DEPTH];
  byte_t           io_reg [IO_COUNT];

  // Output flops.
  logic            ready_reg;
  logic            res_valid_reg;
  logic            res_valid_next;
  logic            res_we_reg;
  logic            res_we_next;
  byte_t           res_data_reg;
  byte_t           res_data_next;
  byte_t           rdata_reg;
  byte_t           rdata_next;

  // Issue decode.
  wire logic       accept;
  wire logic       is_stack;
  wire logic       exec;
  wire logic       in_stack;
  wire logic       pend_store;
  wire logic       pend_load;

  // An instruction is taken only while the sequencer is idle.
  assign accept     = op_valid && (state_reg == st_idle);
  assign is_stack   = (op == op_stack_store) || (op == op_stack_load);
  // Stack transfers go through the sequencer, not the single-cycle path.
  assign exec       = accept && !is_stack;
  assign in_stack   = (state_reg == st_stack);
  assign pend_store = in_stack && (pend_op_reg == op_stack_store);
  assign pend_load  = in_stack && (pend_op_reg == op_stack_load);

  // Shifter outputs.
  byte_t           sh_result;
  logic            sh_carry;
  logic            sh_carry_we;
  logic            sh_hit;

  // The shifter works on the source byte and the current carry.
  // The unit reports through hit whether it owns the operation.
  shift_unit u_shift (
    .op        (op),
    .value     (src_data),
    .carry_in  (status_reg[`BSF_FLAG_C]),
    .result    (sh_result),
    .carry_out (sh_carry),
    .carry_we  (sh_carry_we),
    .hit       (sh_hit)
  );

  // Named flag decode.
  wire logic [4:0] named;
  wire logic       named_hit;
  wire logic [2:0] named_idx;
  wire logic       named_val;

  assign named     = named_flag(op);
  assign named_hit = named[4];
  assign named_idx = named[3:1];
  assign named_val = named[0];

  // Bus decode: the I/O area sits at the bottom of the address space.
  wire logic       bus_io;
  wire logic       bus_wr_io;
  wire logic       bus_wr_status;
  wire logic       bus_wr_sp;

  assign bus_io        = {1'b0, reg_addr} < IO_TOP;
  assign bus_wr_io     = reg_wr && bus_io;
  assign bus_wr_status = reg_wr && (reg_addr == `BSF_ADDR_STATUS);
  assign bus_wr_sp     = reg_wr && (reg_addr == `BSF_ADDR_SP);
  // A write to an unmapped address matches no decode and is dropped.

  // I/O read-modify-write: only the selected bit changes.
  wire logic       io_hit;
  wire byte_t      io_new;

  assign io_hit = exec && ((op == op_io_bit_raise) || (op == op_io_bit_drop));
  assign io_new = bit_put(io_reg[io_index], bit_index, op == op_io_bit_raise);

  // Status register update for one single-cycle instruction.
  wire byte_t      status_exec;

  // At most one term matches a real operation, so the order is free.
  assign status_exec =
    (op == op_status_bit_raise) ? bit_put(status_reg, bit_index, 1'b1) :
    (op == op_status_bit_drop) ? bit_put(status_reg, bit_index, 1'b0) :
    (op == op_store_bit_to_transfer_flag) ?
      bit_put(status_reg, `BSF_FLAG_T, src_data[bit_index]) :
    named_hit ? bit_put(status_reg, named_idx, named_val) :
    sh_carry_we ? bit_put(status_reg, `BSF_FLAG_C, sh_carry) :
    status_reg;

  // A software write to the status register wins over an instruction.
  assign status_next = bus_wr_status ? reg_wdata : (exec ? status_exec : status_reg);

  // Byte produced by a single-cycle instruction for the destination.
  wire byte_t      result_exec;
  wire logic       we_exec;

  assign result_exec = sh_hit ? sh_result :
    bit_put(src_data, bit_index, status_reg[`BSF_FLAG_T]);
  assign we_exec = sh_hit || (op == op_load_bit_from_transfer_flag);

  // Stack pointer: post-decrement on store, pre-increment on load.
  wire logic [SP_W-1:0] sp_up;

  assign sp_up   = sp_reg + SP_W'(1);
  // A software write to the pointer wins over a stack transfer.
  assign sp_next = bus_wr_sp ? reg_wdata[SP_W-1:0] :
    pend_store ? sp_reg - SP_W'(1) :
    pend_load ? sp_up : sp_reg;

  // Sequencer: stack transfers hold the issue port for one extra cycle.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      // Only a stack transfer leaves idle.
      st_idle: begin
        if (accept && is_stack) begin
          state_next = st_stack;
        end
      end
      // The second stack cycle always ends the transfer.
      st_stack: begin
        state_next = st_idle;
      end
      // An unused code falls back to idle.
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  // Result selection for the cycle after an instruction completes.
  assign res_valid_next = exec || in_stack;
  assign res_we_next    = exec ? we_exec : pend_load;
  // A stack store has no data, so the result shows zero then.
  assign res_data_next  = exec ? result_exec :
    pend_load ? stack_mem[sp_up] :
    `BSF_DATA_RST;

  // Register port read decode.
  always_comb begin
    rdata_next = `BSF_DATA_RST;
    if (!reg_rd) begin
      // No strobe, no data.
      rdata_next = `BSF_DATA_RST;
    end else if (bus_io) begin
      // The low address bits pick one I/O register.
      rdata_next = io_reg[reg_addr[IO_W-1:0]];
    end else if (reg_addr == `BSF_ADDR_STATUS) begin
      // Status as it stands now.
      rdata_next = status_reg;
    end else if (reg_addr == `BSF_ADDR_SP) begin
      // The pointer sits in the low bits, the rest read zero.
      rdata_next = 8'(sp_reg);
    end else if (reg_addr == `BSF_ADDR_RESULT) begin
      // The last result handed to the register file.
      rdata_next = res_data_reg;
    end else begin
      // Unmapped addresses read zero.
      rdata_next = `BSF_DATA_RST;
    end
  end

  // Sequencer and held stack request.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Nothing is pending after reset.
      state_reg     <= st_idle;
      pend_op_reg   <= op_nop;
      pend_data_reg <= `BSF_DATA_RST;
    end else begin
      state_reg <= state_next;
      if (accept && is_stack) begin
        // Keep the request for the second cycle.
        pend_op_reg   <= op;
        pend_data_reg <= src_data;
      end
    end
  end

  // Status register and stack pointer.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Flags clear and the pointer starts at the top word.
      status_reg <= `BSF_STATUS_RST;
      sp_reg     <= SP_RST;
    end else begin
      status_reg <= status_next;
      sp_reg     <= sp_next;
    end
  end

  // Stack storage in flip-flops.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_mem[i] <= `BSF_DATA_RST;
      end
    end else if (pend_store) begin
      // The pointer moves down at this same edge.
      stack_mem[sp_reg] <= pend_data_reg;
    end
  end

  // I/O registers; a software write wins over an instruction.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < IO_COUNT; i++) begin
        io_reg[i] <= `BSF_DATA_RST;
      end
    end else if (bus_wr_io) begin
      // A software write replaces the whole byte.
      io_reg[reg_addr[IO_W-1:0]] <= reg_wdata;
    end else if (io_hit) begin
      // Only the selected bit changes.
      io_reg[io_index] <= io_new;
    end
  end

  // Result and handshake outputs.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ready_reg     <= 1'b0;
      res_valid_reg <= 1'b0;
      res_we_reg    <= 1'b0;
      res_data_reg  <= `BSF_DATA_RST;
    end else begin
      // Ready shows the state of the coming cycle.
      ready_reg     <= (state_next == st_idle);
      res_valid_reg <= res_valid_next;
      res_we_reg    <= res_we_next;
      // Result data hold until the next result.
      if (res_valid_next) begin
        res_data_reg <= res_data_next;
      end
    end
  end

  // Read data stand for one cycle after the read strobe.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_reg <= `BSF_DATA_RST;
    end else begin
      // Zero outside the cycle after a read strobe.
      rdata_reg <= rdata_next;
    end
  end

  // Outputs come straight from flops.
  assign op_ready   = ready_reg;
  assign res_valid  = res_valid_reg;
  assign res_we     = res_we_reg;
  assign res_data   = res_data_reg;
  assign status_out = status_reg;
  assign reg_rdata  = rdata_reg;

endmodule

/* File: sim/bsf_properties.sv */
// Concurrent checks on the ports of the bit, shift and flag datapath.
`timescale 1ns/1ps
module bsf_properties (
  // Clock and reset.
  input wire logic     clock,
  input wire logic     nrst,
  // Instruction side.
  input wire logic     op_valid,
  input bsf_pkg::op_e  op,
  input bsf_pkg::byte_t src_data,
  input wire logic [2:0] bit_index,
  input wire logic     op_ready,
  input wire logic     res_valid,
  input wire logic     res_we,
  input bsf_pkg::byte_t res_data,
  input bsf_pkg::byte_t status_out,
  // Register port.
  input wire logic     reg_wr,
  input wire logic     reg_rd,
  input bsf_pkg::byte_t reg_rdata
);
  import bsf_pkg::*;
  byte_t      src_q;  // Operand of the last edge.
  byte_t      st_q;   // Status of the last edge.
  logic [2:0] b_q;    // Bit index of the last edge.
  wire tk = op_valid && op_ready;  // Instruction taken.
  wire fk = tk && !reg_wr;         // Taken with no software register write beside it.
  wire stk = (op == op_stack_store) || (op == op_stack_load);
  // Keep the operands of the previous edge for the checks below.
  always_ff @(posedge clock) begin
    src_q <= src_data;
    st_q  <= status_out;
    b_q   <= bit_index;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // A stack transfer holds the block for one cycle, then answers.
  sequence s_stack; tk && stk; endsequence
  sequence s_done; !op_ready ##1 (res_valid && op_ready); endsequence
  chk_stack_timing: assert property (s_stack |=> s_done)
    else $error("stack op timing wrong");
  chk_single_answer: assert property (tk && !stk |=> res_valid && op_ready)
    else $error("single op gave no result");
  chk_shift_left: assert property (fk && op == op_logical_shift_left |=>
    res_we && res_data == {src_q[6:0], 1'b0} && status_out == st_q) else $error("left shift wrong");
  chk_shift_right: assert property (fk && op == op_logical_shift_right |=>
    res_we && res_data == {1'b0, src_q[7:1]}) else $error("right shift wrong");
  chk_rotate_left: assert property (fk && op == op_rotate_left_via_carry |=>
    res_data == {src_q[6:0], st_q[0]} && status_out == {st_q[7:1], src_q[7]}) else $error("rotate left wrong");
  chk_rotate_right: assert property (fk && op == op_rotate_right_via_carry |=>
    res_data == {st_q[0], src_q[7:1]} && status_out == {st_q[7:1], src_q[0]}) else $error("rotate right wrong");
  chk_arith_right: assert property (tk && op == op_arith_shift_right |=>
    res_data == {src_q[7], src_q[7:1]}) else $error("arith shift wrong");
  chk_nibble_swap: assert property (tk && op == op_nibble_exchange |=>
    res_data == {src_q[3:0], src_q[7:4]}) else $error("swap wrong");
  chk_status_set: assert property (fk && op == op_status_bit_raise |=>
    status_out == (st_q | (8'h01 << b_q))) else $error("status set wrong");
  chk_status_clear: assert property (fk && op == op_status_bit_drop |=>
    status_out == (st_q & ~(8'h01 << b_q))) else $error("status clear wrong");
  chk_bit_store: assert property (fk && op == op_store_bit_to_transfer_flag |=>
    status_out == {st_q[7], src_q[b_q], st_q[5:0]}) else $error("bit store wrong");
  chk_bit_load: assert property (tk && op == op_load_bit_from_transfer_flag |=> res_we &&
    res_data == ((src_q & ~(8'h01 << b_q)) | ({7'h00, st_q[6]} << b_q))) else $error("bit load wrong");
  chk_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule
bind bit_shift_flag_datapath bsf_properties u_chk (.clock(clock), .nrst(nrst), .op_valid(op_valid),
  .op(op), .src_data(src_data), .bit_index(bit_index), .op_ready(op_ready), .res_valid(res_valid),
  .res_we(res_we), .res_data(res_data), .status_out(status_out), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));

/* File: sim/issue_model.sv */
// Decoder-side model that issues instructions and keeps the gap after stack ops.
`timescale 1ns/1ps
module issue_model (
  // Core clock.
  input wire logic       clock,
  // Instruction issue towards the datapath.
  output logic           op_valid,
  output bsf_pkg::op_e   op,
  output bsf_pkg::byte_t src_data,
  output logic [2:0]     bit_index,
  output logic [4:0]     io_index
);
  import bsf_pkg::*;
  // Nothing requested; the operand toggles so a stale value never looks valid.
  task automatic idle();
    op_valid <= 1'b0;
    src_data <= ~src_data;
  endtask
  // Present one instruction for one edge; a stack op is followed by one idle cycle.
  task automatic issue(input op_e o, input byte_t d, input logic [2:0] b, input logic [4:0] p);
    op_valid  <= 1'b1;
    op        <= o;
    src_data  <= d;
    bit_index <= b;
    io_index  <= p;
    @(posedge clock);
    if (o == op_stack_store || o == op_stack_load) begin
      idle();
      @(posedge clock);
    end
  endtask
  // Quiet at time zero.
  initial begin
    op_valid  = 1'b0;
    op        = op_nop;
    src_data  = 8'h00;
    bit_index = 3'h0;
    io_index  = 5'h00;
  end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the bit, shift and flag datapath.
`timescale 1ns/1ps
`include "bsf_map.svh"
module tb_top;
  import bsf_pkg::*;
  // Expected outcome of one instruction: write flag, data-compare flag, data, status.
  typedef struct {logic we; logic cd; byte_t d; byte_t s;} exp_s;
  logic       clock = 1'b0;
  logic       nrst = 1'b0;
  logic       op_valid, op_ready, res_valid, res_we;
  op_e        op;
  byte_t      src_data, res_data, status_out, reg_rdata;
  logic [2:0] bit_index;
  logic [4:0] io_index;
  logic [5:0] reg_addr = 6'h00;
  byte_t      reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  int         n_errors = 0, n_tests = 0, cyc = 0, seed = 32'hbae1b679;
  exp_s       exp_q[$], m_e;
  byte_t      rd_q[$], io[32], stk[16], last;
  byte_t      st = `BSF_STATUS_RST;  // Status model.
  logic [3:0] sp = 4'hF;             // Stack pointer model.
  logic       rd_d = 1'b0;
  // Flag of each named raise/drop pair, in opcode order.
  localparam logic [2:0] FLAG_OF[8] = '{`BSF_FLAG_C, `BSF_FLAG_N, `BSF_FLAG_Z, `BSF_FLAG_I,
                                        `BSF_FLAG_S, `BSF_FLAG_V, `BSF_FLAG_T, `BSF_FLAG_H};
  always #2 clock = ~clock;
  bit_shift_flag_datapath dut (.clock(clock), .nrst(nrst), .op_valid(op_valid), .op(op),
    .src_data(src_data), .bit_index(bit_index), .io_index(io_index), .op_ready(op_ready),
    .res_valid(res_valid), .res_we(res_we), .res_data(res_data), .status_out(status_out),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  issue_model u_dec (.clock(clock), .op_valid(op_valid), .op(op), .src_data(src_data),
    .bit_index(bit_index), .io_index(io_index));
  // Compare one byte and count it.
  task automatic check(input byte_t g, input byte_t e, input string m);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic tally_and_finish();
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Register port: one-cycle strobes, lowered together by rest.
  task automatic wr(input logic [5:0] a, input byte_t d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask
  task automatic rd(input logic [5:0] a, input byte_t e);
    rd_q.push_back(e);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge clock);
  endtask
  task automatic rest();
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  // Predict one instruction, note it, then hand it to the issuer.
  task automatic run(input op_e o, input byte_t d, input logic [2:0] b, input logic [4:0] p);
    exp_s e;
    int k;
    k = int'(o) - 15;
    e.d = d;
    e.we = o inside {[op_logical_shift_left:op_nibble_exchange], op_stack_load, op_load_bit_from_transfer_flag};
    e.cd = e.we | (o == op_nop);
    case (o)
      op_nop: e.d[b] = st[6];
      op_stack_store: begin stk[sp] = d; sp--; end
      op_stack_load: begin sp++; e.d = stk[sp]; end
      op_io_bit_raise: io[p][b] = 1'b1;
      op_io_bit_drop: io[p][b] = 1'b0;
      op_logical_shift_left: e.d = {d[6:0], 1'b0};
      op_logical_shift_right: e.d = {1'b0, d[7:1]};
      op_rotate_left_via_carry: begin e.d = {d[6:0], st[0]}; st[0] = d[7]; end
      op_rotate_right_via_carry: begin e.d = {st[0], d[7:1]}; st[0] = d[0]; end
      op_arith_shift_right: e.d = {d[7], d[7:1]};
      op_nibble_exchange: e.d = {d[3:0], d[7:4]};
      op_status_bit_raise: st[b] = 1'b1;
      op_status_bit_drop: st[b] = 1'b0;
      op_store_bit_to_transfer_flag: st[6] = d[b];
      op_load_bit_from_transfer_flag: e.d[b] = st[6];
      default: st[FLAG_OF[k / 2]] = (k % 2 == 0);
    endcase
    e.s = st;
    if (e.cd) last = e.d;
    exp_q.push_back(e);
    u_dec.issue(o, d, b, p);
  endtask
  // Watch the outputs: cut a hang short, check reads and results against the notes.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
    if (rd_d) check(reg_rdata, rd_q.pop_front(), "read");
    rd_d = reg_rd;
    if (nrst && res_valid) begin
      m_e = exp_q.pop_front();
      check({7'h00, res_we}, {7'h00, m_e.we}, "write flag");
      if (m_e.cd) check(res_data, m_e.d, "result");
      check(status_out, m_e.s, "status");
    end
  end
  // Main sequence: reset values, every op then random ops with stalls, then the register port.
  initial begin
    logic [31:0] r;
    op_e o;
    for (int i = 0; i < 32; i++) io[i] = `BSF_DATA_RST;
    for (int i = 0; i < 16; i++) stk[i] = `BSF_DATA_RST;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    rd(`BSF_ADDR_STATUS, `BSF_STATUS_RST);
    rd(`BSF_ADDR_SP, 8'h0F);
    rest();
    for (int i = 0; i < 500; i++) begin
      r = $random(seed);
      o = (i < 30) ? op_e'(i) : op_e'($unsigned($random(seed)) % 30);
      if (r[31:29] == 3'h0) begin
        u_dec.idle();
        @(posedge clock);
      end
      run(o, r[7:0], r[10:8], r[15:11]);
    end
    run(op_nibble_exchange, 8'h3C, 3'h0, 5'h00);
    u_dec.idle();
    repeat (3) @(posedge clock);
    for (int a = 0; a < 32; a++) rd(a[5:0], io[a]);
    rd(`BSF_ADDR_STATUS, st);
    rd(`BSF_ADDR_RESULT, last);
    rd(`BSF_ADDR_SP, {4'h0, sp});
    wr(`BSF_ADDR_STATUS, 8'hA5);
    rd(`BSF_ADDR_STATUS, 8'hA5);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    wr(6'h07, 8'h81);
    rd(6'h07, 8'h81);
    rest();
    st = 8'hA5;
    run(op_rotate_right_via_carry, 8'h02, 3'h0, 5'h00);
    run(op_io_bit_drop, 8'h00, 3'h7, 5'h07);
    u_dec.idle();
    io[7] = 8'h01;
    rd(6'h07, io[7]);
    rest();
    repeat (3) @(posedge clock);
    check(8'(exp_q.size()), 8'h00, "missing results");
    tally_and_finish();
  end
endmodule
